/* File: hw/cms_msg_storage.sv */
// Purpose: transmit buffers, receive FIFO and time stamps of a CAN controller
// Assumes: protocol engine on clock_i drives the engine ports; zero-latency bit tick
// Notes:   APB slave answers with one wait state

module cms_msg_storage (
   // clock and reset
   input wire logic clock_i,
   input wire logic rst_n_i,
   // apb slave
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pwrite_i,
   input wire logic [7:0] paddr_i,
   input wire logic [31:0] pwdata_i,
   output logic [31:0] prdata_o,
   output logic pready_o,
   output logic pslverr_o,
   // bit timing
   input wire logic bit_tick_i,
   // transmit engine
   input wire logic tx_sof_i,
   input wire logic tx_ok_i,
   input wire logic tx_fail_i,
   input wire logic [3:0] tx_rd_addr_i,
   output logic tx_req_o,
   output logic [1:0] tx_idx_o,
   output logic [7:0] tx_rd_data_o,
   // receive engine
   input wire logic rx_we_i,
   input wire logic [3:0] rx_addr_i,
   input wire logic [7:0] rx_data_i,
   input wire logic rx_ack_i,
   input wire logic rx_done_i,
   input wire logic rx_accept_i,
   input wire logic rx_own_i,
   output logic ack_allow_o,
   // interrupts
   output logic tx_irq_o,
   output logic rx_irq_o,
   output logic err_irq_o
);
   import cms_pkg::*;

   // ****************************************************
   // helpers
   // ****************************************************
   function automatic logic [1:0] oh_idx(input logic [2:0] oh);
      return oh[0] ? 2'h0 : (oh[1] ? 2'h1 : 2'h2);
   endfunction

   function automatic logic [2:0] ptr_inc(input logic [2:0] p);
      return (p == CMS_FIFO_DEPTH - 3'h1) ? 3'h0 : p + 3'h1;
   endfunction

   // ****************************************************
   // state
   // ****************************************************
   logic pready_q, pslverr_q;
   logic [31:0] prdata_q, rd_val;
   logic [2:0] ctrl_q, ie_q;
   logic [2:0] tx_empty_q, tx_sel_q, abort_q, abort_ack_q;
   logic tx_busy_q;
   logic [1:0] tx_active_q;
   cms_stamp_t timer_q;
   cms_byte_t tx_mem [CMS_NUM_TX][CMS_TX_BYTES];
   cms_stamp_t tx_stamp [CMS_NUM_TX];
   cms_byte_t bg_mem [CMS_RX_BYTES];
   cms_byte_t fifo_mem [CMS_FIFO_DEPTH][CMS_RX_BYTES];
   logic [2:0] rd_ptr_q, wr_ptr_q, count_q;
   logic ovr_q;
   logic [7:0] tx_rd_q;
   logic tx_req_q, ack_allow_q, tx_irq_q, rx_irq_q, err_irq_q;

   cms_sched_if sif ();

   // ****************************************************
   // apb decode
   // ****************************************************
   wire acc_start = psel_i & penable_i & ~pready_q;
   wire do_wr = psel_i & penable_i & pready_q & pwrite_i & ~pslverr_q;
   wire [3:0] widx = paddr_i[5:2];
   wire in_txw = (paddr_i[7:6] == CMS_WIN_TX);
   wire in_rxw = (paddr_i[7:6] == CMS_WIN_RX) & (widx < 4'(CMS_RX_BYTES));
   wire hit_ctrl = (paddr_i == CMS_ADDR_CTRL);
   wire hit_txflag = (paddr_i == CMS_ADDR_TX_FLAG);
   wire hit_txsel = (paddr_i == CMS_ADDR_TX_SEL);
   wire hit_abrq = (paddr_i == CMS_ADDR_ABORT_REQ);
   wire hit_abak = (paddr_i == CMS_ADDR_ABORT_ACK);
   wire hit_rxflag = (paddr_i == CMS_ADDR_RX_FLAG);
   wire hit_ie = (paddr_i == CMS_ADDR_IRQ_EN);
   wire hit_timer = (paddr_i == CMS_ADDR_TIMER);
   wire mapped = hit_ctrl | hit_txflag | hit_txsel | hit_abrq | hit_abak | hit_rxflag
                 | hit_ie | hit_timer | in_txw | in_rxw;
   wire [1:0] sel_idx = oh_idx(tx_sel_q);
   // window open only on a selected empty buffer
   wire sel_ok = |(tx_sel_q & tx_empty_q);
   wire tx_win_wr = do_wr & in_txw & sel_ok & (widx <= CMS_TXW_LOCAL_PRIORITY);
   wire init_mode = ctrl_q[CMS_CTRL_INIT];
   wire time_en = ctrl_q[CMS_CTRL_TIME];
   wire loop_en = ctrl_q[CMS_CTRL_LOOP];
   wire [2:0] clr_empty = (do_wr & hit_txflag) ? pwdata_i[2:0] : 3'h0;
   wire [2:0] sel_cand = pwdata_i[2:0] & tx_empty_q;
   wire [2:0] sel_low = sel_cand & (~sel_cand + 3'h1);
   wire rx_full = (count_q != 3'h0);
   wire [15:0] act_stamp = tx_stamp[sel_idx];
   wire [15:0] fg_stamp = {fifo_mem[rd_ptr_q][CMS_RXW_STAMP_HI],
                           fifo_mem[rd_ptr_q][CMS_RXW_STAMP_LO]};

   always_comb begin
      rd_val = 32'h0;
      if (hit_ctrl) rd_val[2:0] = ctrl_q;
      if (hit_txflag) rd_val[2:0] = tx_empty_q;
      if (hit_txsel) rd_val[2:0] = tx_sel_q;
      if (hit_abrq) rd_val[2:0] = abort_q;
      if (hit_abak) rd_val[2:0] = abort_ack_q;
      if (hit_rxflag) rd_val[1:0] = {ovr_q, rx_full};
      if (hit_ie) rd_val[2:0] = ie_q;
      if (hit_timer) rd_val[15:0] = timer_q;
      // stamp readable once the selected buffer is empty
      if (in_txw && sel_ok) begin
         if (widx == CMS_TXW_STAMP_HI) rd_val[7:0] = act_stamp[15:8];
         else if (widx == CMS_TXW_STAMP_LO) rd_val[7:0] = act_stamp[7:0];
         else rd_val[7:0] = tx_mem[sel_idx][widx];
      end
      // only the foreground entry is visible
      if (in_rxw && rx_full) rd_val[7:0] = fifo_mem[rd_ptr_q][widx];
   end

   always_ff @(posedge clock_i) begin
      if (!rst_n_i) begin
         pready_q <= 1'h0;
         pslverr_q <= 1'h0;
         prdata_q <= 32'h0;
      end else begin
         pready_q <= acc_start;
         pslverr_q <= acc_start & ~mapped;
         prdata_q <= (acc_start & ~pwrite_i) ? rd_val : 32'h0;
      end
   end

   // ****************************************************
   // control registers
   // ****************************************************
   always_ff @(posedge clock_i) begin
      if (!rst_n_i) begin
         ctrl_q <= CMS_CTRL_RST;
         ie_q <= CMS_IE_RST;
         tx_sel_q <= 3'h0;
      end else begin
         if (do_wr && hit_ctrl) ctrl_q <= pwdata_i[2:0];
         if (do_wr && hit_ie) ie_q <= pwdata_i[2:0];
         // lowest requested empty buffer is mapped
         if (do_wr && hit_txsel) tx_sel_q <= sel_low;
      end
   end

   // ****************************************************
   // stamp timer
   // ****************************************************
   always_ff @(posedge clock_i) begin
      if (!rst_n_i) begin
         timer_q <= 16'h0;
      end else if (init_mode) begin
         timer_q <= 16'h0;
      end else if (bit_tick_i) begin
         timer_q <= timer_q + 16'h1;
      end
   end

   // ****************************************************
   // transmit buffers
   // ****************************************************
   // empty and abort-requested buffers stay out of arbitration
   assign sif.pending = ~tx_empty_q & ~abort_q;
   always_comb begin
      for (int i = 0; i < CMS_NUM_TX; i++) begin
         sif.local_priority[i] = tx_mem[i][CMS_TXW_LOCAL_PRIORITY];
      end
   end

   cms_tx_sched u_sched (
      .s(sif.sched)
   );

   for (genvar g = 0; g < CMS_NUM_TX; g++) begin : g_tx
      wire on_air = tx_busy_q & (tx_active_q == 2'(g));
      wire sent = tx_ok_i & on_air;
      // frames on the bus cannot be aborted
      wire grant = abort_q[g] & ~tx_empty_q[g] & ~on_air;
      always_ff @(posedge clock_i) begin
         if (!rst_n_i) begin
            tx_empty_q[g] <= CMS_TX_EMPTY_RST[g];
            abort_q[g] <= 1'h0;
            abort_ack_q[g] <= 1'h0;
            tx_stamp[g] <= 16'h0;
         end else begin
            // hardware set wins over software clear
            if (sent || grant) tx_empty_q[g] <= 1'h1;
            else if (clr_empty[g]) tx_empty_q[g] <= 1'h0;
            if (grant) abort_ack_q[g] <= 1'h1;
            else if (sent || clr_empty[g]) abort_ack_q[g] <= 1'h0;
            if (sent || grant) abort_q[g] <= 1'h0;
            else if (do_wr && hit_abrq && pwdata_i[g]) abort_q[g] <= 1'h1;
            // stamp at acknowledge; both bytes at once
            if (sent && time_en) tx_stamp[g] <= timer_q;
         end
      end
   end

   // message bytes plus priority byte per buffer
   always_ff @(posedge clock_i) begin
      if (tx_win_wr) tx_mem[sel_idx][widx] <= pwdata_i[7:0];
   end

   always_ff @(posedge clock_i) begin
      if (!rst_n_i || init_mode) begin
         tx_busy_q <= 1'h0;
         tx_active_q <= 2'h0;
      end else if (tx_busy_q) begin
         // lost arbitration ends the attempt, engine keeps receiving
         if (tx_ok_i || tx_fail_i) tx_busy_q <= 1'h0;
      end else if (tx_sof_i && sif.win_valid) begin
         // rearbitrated before every SOF, also after errors
         tx_busy_q <= 1'h1;
         tx_active_q <= sif.win;
      end
   end

   // ****************************************************
   // receive path
   // ****************************************************
   // own frames only queued in loopback; loopback path
   wire take = rx_done_i & rx_accept_i & (~rx_own_i | loop_en) & ~init_mode;
   wire pop = do_wr & hit_rxflag & pwdata_i[CMS_RXF_FULL] & rx_full;
   // a stage freed in the same cycle still accepts
   wire push = take & ((count_q != CMS_FIFO_DEPTH) | pop);
   wire ovr_evt = take & ~push;

   // engine writes the background buffer at any time
   always_ff @(posedge clock_i) begin
      if (rx_we_i && rx_addr_i < 4'(CMS_TX_MSG_BYTES)) bg_mem[rx_addr_i] <= rx_data_i;
      if (rx_ack_i && time_en) begin
         bg_mem[CMS_RXW_STAMP_HI] <= timer_q[15:8];
         bg_mem[CMS_RXW_STAMP_LO] <= timer_q[7:0];
      end
   end

   // whole fifteen-byte entry moves at once
   always_ff @(posedge clock_i) begin
      if (push) fifo_mem[wr_ptr_q] <= bg_mem;
   end

   always_ff @(posedge clock_i) begin
      if (!rst_n_i) begin
         rd_ptr_q <= 3'h0;
         wr_ptr_q <= 3'h0;
         count_q <= 3'h0;
         ovr_q <= 1'h0;
      end else begin
         // queued frame sets the full flag; rejects never pushed
         if (push) wr_ptr_q <= ptr_inc(wr_ptr_q);
         // software clear releases the foreground; next takes over
         if (pop) rd_ptr_q <= ptr_inc(rd_ptr_q);
         if (push && !pop) count_q <= count_q + 3'h1;
         else if (pop && !push) count_q <= count_q - 3'h1;
         if (ovr_evt) ovr_q <= 1'h1;
         else if (do_wr && hit_rxflag && pwdata_i[CMS_RXF_OVR]) ovr_q <= 1'h0;
      end
   end

   // ****************************************************
   // registered outputs
   // ****************************************************
   always_ff @(posedge clock_i) begin
      if (!rst_n_i) begin
         tx_req_q <= 1'h0;
         ack_allow_q <= 1'h1;
         tx_rd_q <= 8'h0;
         tx_irq_q <= 1'h0;
         rx_irq_q <= 1'h0;
         err_irq_q <= 1'h0;
      end else begin
         tx_req_q <= sif.win_valid & ~tx_busy_q & ~init_mode;
         // no acknowledge of own frame unless loopback
         ack_allow_q <= ~(tx_busy_q & ~loop_en);
         tx_rd_q <= (tx_rd_addr_i < 4'(CMS_TX_MSG_BYTES)) ? tx_mem[tx_active_q][tx_rd_addr_i]
                                                          : 8'h0;
         // interrupt while any empty flag stands
         tx_irq_q <= ie_q[CMS_IE_TX] & (|tx_empty_q);
         rx_irq_q <= ie_q[CMS_IE_RX] & rx_full;
         err_irq_q <= ie_q[CMS_IE_OVR] & ovr_q;
      end
   end

   assign prdata_o = prdata_q;
   assign pready_o = pready_q;
   assign pslverr_o = pslverr_q;
   assign tx_req_o = tx_req_q;
   assign tx_idx_o = tx_active_q;
   assign tx_rd_data_o = tx_rd_q;
   assign ack_allow_o = ack_allow_q;
   assign tx_irq_o = tx_irq_q;
   assign rx_irq_o = rx_irq_q;
   assign err_irq_o = err_irq_q;

   // ****************************************************
   // assertions
   // ****************************************************
   default clocking cb @(posedge clock_i); endclocking
   default disable iff (!rst_n_i);

   chk_timer_init_zero: assert property (init_mode |=> timer_q == 16'h0)
      else $error("timer not zero in init");
   chk_sent_sets_empty: assert property (tx_ok_i && tx_busy_q |=>
      tx_empty_q[$past(tx_active_q)] && !abort_ack_q[$past(tx_active_q)])
      else $error("sent buffer not released cleanly");
   chk_abort_grant_ack: assert property (abort_q[0] && !tx_empty_q[0] &&
      !(tx_busy_q && tx_active_q == 2'h0) |=> abort_ack_q[0] && tx_empty_q[0] ##1 tx_irq_o
      || !ie_q[CMS_IE_TX])
      else $error("abort not acknowledged");
   chk_stamp_capture: assert property (tx_ok_i && tx_busy_q && time_en |=>
      tx_stamp[$past(tx_active_q)] == $past(timer_q))
      else $error("stamp not taken at acknowledge");
   chk_sof_pick_win: assert property (tx_sof_i && sif.win_valid && !tx_busy_q && !init_mode
      |=> tx_busy_q && tx_active_q == $past(sif.win) ##1 tx_idx_o == $past(sif.win, 2))
      else $error("wrong buffer started");
   chk_rx_push_count: assert property (take && !pop && count_q < CMS_FIFO_DEPTH |=>
      count_q == $past(count_q) + 3'h1 ##1 rx_irq_o || !ie_q[CMS_IE_RX])
      else $error("accepted frame not queued");
   chk_overrun_drop: assert property (take && !pop && count_q == CMS_FIFO_DEPTH |=>
      ovr_q && count_q == CMS_FIFO_DEPTH)
      else $error("overrun not flagged");
   chk_own_not_queued: assert property (rx_done_i && rx_own_i && !loop_en && !pop |=>
      $stable(count_q))
      else $error("own frame queued");
   chk_refill_full: assert property (pop && count_q > 3'h1 && !take |=>
      rx_full && rd_ptr_q == ptr_inc($past(rd_ptr_q)))
      else $error("foreground not refilled");
   chk_no_self_ack: assert property (tx_busy_q && !loop_en |=> !ack_allow_o)
      else $error("own frame acknowledged");

endmodule // cms_msg_storage

/* File: hw/cms_pkg.sv */
// Purpose: shared constants and types of the CAN message storage block
// Assumes: 32-bit APB, one word per register, byte data in the low lanes
// Notes:   window byte index is paddr[5:2]

package cms_pkg;

   // ****************************************************
   // sizes
   // ****************************************************
   localparam int CMS_NUM_TX = 3;
   localparam int CMS_TX_MSG_BYTES = 13;
   localparam int CMS_TX_BYTES = 14;
   localparam int CMS_RX_BYTES = 15;
   localparam logic [2:0] CMS_FIFO_DEPTH = 3'h5;

   typedef logic [7:0] cms_byte_t;
   typedef logic [15:0] cms_stamp_t;

   // ****************************************************
   // register byte addresses
   // ****************************************************
   localparam logic [7:0] CMS_ADDR_CTRL = 8'h00;
   localparam logic [7:0] CMS_ADDR_TX_FLAG = 8'h04;
   localparam logic [7:0] CMS_ADDR_TX_SEL = 8'h08;
   localparam logic [7:0] CMS_ADDR_ABORT_REQ = 8'h0C;
   localparam logic [7:0] CMS_ADDR_ABORT_ACK = 8'h10;
   localparam logic [7:0] CMS_ADDR_RX_FLAG = 8'h14;
   localparam logic [7:0] CMS_ADDR_IRQ_EN = 8'h18;
   localparam logic [7:0] CMS_ADDR_TIMER = 8'h1C;
   localparam logic [1:0] CMS_WIN_TX = 2'h1;
   localparam logic [1:0] CMS_WIN_RX = 2'h2;

   // ****************************************************
   // byte positions inside the windows
   // ****************************************************
   localparam logic [3:0] CMS_TXW_LOCAL_PRIORITY = 4'hD;
   localparam logic [3:0] CMS_TXW_STAMP_HI = 4'hE;
   localparam logic [3:0] CMS_TXW_STAMP_LO = 4'hF;
   localparam logic [3:0] CMS_RXW_STAMP_HI = 4'hD;
   localparam logic [3:0] CMS_RXW_STAMP_LO = 4'hE;

   // ****************************************************
   // field positions and reset values
   // ****************************************************
   localparam int CMS_CTRL_INIT = 0;
   localparam int CMS_CTRL_TIME = 1;
   localparam int CMS_CTRL_LOOP = 2;
   localparam int CMS_IE_TX = 0;
   localparam int CMS_IE_RX = 1;
   localparam int CMS_IE_OVR = 2;
   localparam int CMS_RXF_FULL = 0;
   localparam int CMS_RXF_OVR = 1;
   localparam logic [2:0] CMS_CTRL_RST = 3'h1;
   localparam logic [2:0] CMS_TX_EMPTY_RST = 3'h7;
   localparam logic [2:0] CMS_IE_RST = 3'h0;

endpackage : cms_pkg

/* File: hw/cms_sched_if.sv */
// Purpose: carrier between the storage core and the transmit scheduler
// Assumes: three transmit buffers
// Notes:   purely combinational signals

interface cms_sched_if;
   logic [2:0] pending;
   logic [2:0][7:0] local_priority;
   logic [1:0] win;
   logic win_valid;

   modport sched (input pending, input local_priority, output win, output win_valid);
   modport core (output pending, output local_priority, input win, input win_valid);
endinterface : cms_sched_if

/* File: hw/cms_tx_sched.sv */
// Purpose: picks the pending transmit buffer with the smallest local priority
// Assumes: pending already excludes empty and abort-requested buffers
// Notes:   strict less-than keeps the lower index on a tie

module cms_tx_sched (
   // scheduler side of the carrier
   cms_sched_if.sched s
);
   import cms_pkg::*;

   // ****************************************************
   // selection
   // ****************************************************
   function automatic logic [2:0] pick(input logic [2:0] pend, input logic [2:0][7:0] pr);
      logic found;
      logic [1:0] best;
      logic [7:0] best_p;
      found = 1'h0;
      best = 2'h0;
      best_p = 8'hFF;
      for (int i = 0; i < CMS_NUM_TX; i++) begin
         if (pend[i] && (!found || pr[i] < best_p)) begin
            found = 1'h1;
            best = 2'(i);
            best_p = pr[i];
         end
      end
      return {found, best};
   endfunction

   assign {s.win_valid, s.win} = pick(s.pending, s.local_priority);

endmodule // cms_tx_sched

/* File: tb/cms_engine_model.sv */
// Purpose: protocol engine stand-in on the far side of the storage block
// Assumes: same clock as the block, strobes are one-cycle pulses
// Notes:   released data lines show the inverse of the last value, not a held copy

module cms_engine_model (
   // clock and bit-time gate
   input wire logic clock_i,
   input wire logic tick_en,
   // bit timing
   output logic bit_tick_i,
   // transmit side
   output logic tx_sof_i = 1'b0,
   output logic tx_ok_i = 1'b0,
   output logic tx_fail_i = 1'b0,
   output logic [3:0] tx_rd_addr_i = 4'h0,
   // receive side
   output logic rx_we_i = 1'b0,
   output logic [3:0] rx_addr_i = 4'h0,
   output logic [7:0] rx_data_i = 8'h00,
   output logic rx_ack_i = 1'b0,
   output logic rx_done_i = 1'b0,
   output logic rx_accept_i = 1'b0,
   output logic rx_own_i = 1'b0
);
   timeunit 1ns;
   timeprecision 1ps;

   // the bench freezes the bit clock so stamps are predictable
   assign bit_tick_i = tick_en;

   task automatic tx_start();
      @(posedge clock_i);
      tx_sof_i <= 1'b1;
      @(posedge clock_i);
      tx_sof_i <= 1'b0;
      @(posedge clock_i);
   endtask

   // attempt ends by error or lost arbitration, no success pulse
   task automatic tx_lose();
      @(posedge clock_i);
      tx_fail_i <= 1'b1;
      @(posedge clock_i);
      tx_fail_i <= 1'b0;
   endtask

   task automatic tx_end();
      @(posedge clock_i);
      tx_ok_i <= 1'b1;
      @(posedge clock_i);
      tx_ok_i <= 1'b0;
      repeat (2) @(posedge clock_i);
   endtask

   task automatic rx_frame(input logic own, input logic acc, input logic [7:0] tag);
      @(posedge clock_i);
      rx_we_i <= 1'b1;
      rx_data_i <= tag;
      @(posedge clock_i);
      rx_we_i <= 1'b0;
      rx_data_i <= ~tag;
      rx_ack_i <= 1'b1;
      @(posedge clock_i);
      rx_ack_i <= 1'b0;
      rx_done_i <= 1'b1;
      rx_accept_i <= acc;
      rx_own_i <= own;
      @(posedge clock_i);
      rx_done_i <= 1'b0;
      rx_accept_i <= ~acc;
      rx_own_i <= ~own;
      repeat (2) @(posedge clock_i);
   endtask
endmodule // cms_engine_model

/* File: tb/test_can_message_storage.sv */
// Purpose: self-checking bench for the CAN message storage block
// Assumes: APB slave with one wait state, engine stand-in on the same clock
// Notes:   timer is frozen before the first frame so stamps are known

module test_can_message_storage;
   timeunit 1ns;
   timeprecision 1ps;
   import cms_pkg::*;
   logic clock_i = 1'b0;
   logic rst_n_i = 1'b0;
   logic psel_i = 1'b0;
   logic penable_i = 1'b0;
   logic pwrite_i = 1'b0;
   logic [7:0] paddr_i = 8'h00;
   logic [31:0] pwdata_i = 32'h0;
   logic tick_en = 1'b1;
   wire logic [31:0] prdata_o;
   wire logic [1:0] tx_idx_o;
   wire logic [7:0] tx_rd_data_o, rx_data_i;
   wire logic [3:0] tx_rd_addr_i, rx_addr_i;
   wire logic pready_o, pslverr_o, tx_req_o, ack_allow_o, tx_irq_o, rx_irq_o, err_irq_o;
   wire logic bit_tick_i, tx_sof_i, tx_ok_i, tx_fail_i, rx_we_i, rx_ack_i;
   wire logic rx_done_i, rx_accept_i, rx_own_i;
   logic [31:0] rdata, tstamp;
   logic perr;
   int mismatches = 0;
   int compares = 0;
   int cycles = 0;

   cms_msg_storage dut (.*);
   cms_engine_model eng (.*);

   initial forever #2.5 clock_i = ~clock_i;

   // ****************************************************
   // access and compare helpers
   // ****************************************************
   function automatic logic [7:0] win(input logic [1:0] w, input logic [3:0] i);
      return {w, i, 2'h0};
   endfunction

   task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         mismatches++;
         $display("mismatch %s expected %h seen %h", name, exp, seen);
      end
   endtask

   task automatic apb(input logic wr, input logic [7:0] addr, input logic [31:0] data);
      @(posedge clock_i);
      psel_i <= 1'b1;
      pwrite_i <= wr;
      paddr_i <= addr;
      pwdata_i <= data;
      @(posedge clock_i);
      penable_i <= 1'b1;
      do @(posedge clock_i); while (pready_o !== 1'b1);
      rdata = prdata_o;
      perr = pslverr_o;
      psel_i <= 1'b0;
      penable_i <= 1'b0;
   endtask

   task automatic rd(input string name, input logic [7:0] addr, input logic [31:0] exp);
      apb(1'b0, addr, 32'h0);
      chk(name, rdata, exp);
   endtask

   task automatic print_verdict();
      if (mismatches == 0 && compares > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask

   // a hang ends the run as a failure
   always @(posedge clock_i) begin
      cycles++;
      if (cycles == 20000) begin
         mismatches++;
         print_verdict();
      end
   end

   // ****************************************************
   // test sequence
   // ****************************************************
   initial begin
      repeat (8) @(posedge clock_i);
      rst_n_i <= 1'b1;
      rd("timer_init", CMS_ADDR_TIMER, 32'h0);
      rd("tx_flag_rst", CMS_ADDR_TX_FLAG, 32'h7);
      apb(1'b0, 8'hBC, 32'h0);
      chk("unmapped", perr, 32'h1);
      apb(1'b1, CMS_ADDR_IRQ_EN, 32'h7);
      apb(1'b1, CMS_ADDR_CTRL, 32'h2);
      for (int i = 0; i < CMS_NUM_TX; i++) begin
         apb(1'b1, CMS_ADDR_TX_SEL, 32'h1 << i);
         apb(1'b1, win(CMS_WIN_TX, 4'h0), 32'h30 + i);
         apb(1'b1, win(CMS_WIN_TX, CMS_TXW_LOCAL_PRIORITY), (i == 0) ? 32'h20 : 32'h10);
         rd("local_priority", win(CMS_WIN_TX, CMS_TXW_LOCAL_PRIORITY), (i == 0) ? 32'h20 : 32'h10);
      end
      tick_en <= 1'b0;
      apb(1'b0, CMS_ADDR_TIMER, 32'h0);
      tstamp = rdata;
      chk("timer_runs", 32'(tstamp != 0), 32'h1);
      apb(1'b1, CMS_ADDR_TX_FLAG, 32'h7);
      rd("tx_ready", CMS_ADDR_TX_FLAG, 32'h0);
      chk("tx_req", tx_req_o, 32'h1);
      chk("tx_irq_idle", tx_irq_o, 32'h0);
      eng.tx_start();
      chk("tx_idx_tie", tx_idx_o, 32'h1);
      // ack gate and read-back byte are launched one edge after the start is seen
      @(posedge clock_i);
      chk("ack_allow", ack_allow_o, 32'h0);
      chk("tx_rd_data", tx_rd_data_o, 32'h31);
      eng.tx_end();
      rd("tx_sent", CMS_ADDR_TX_FLAG, 32'h2);
      apb(1'b1, CMS_ADDR_ABORT_REQ, 32'h1);
      rd("abort_ack", CMS_ADDR_ABORT_ACK, 32'h1);
      rd("abort_empty", CMS_ADDR_TX_FLAG, 32'h3);
      eng.tx_start();
      chk("tx_idx_next", tx_idx_o, 32'h2);
      eng.tx_lose();
      rd("tx_lost", CMS_ADDR_TX_FLAG, 32'h3);
      chk("tx_req_retry", tx_req_o, 32'h1);
      eng.tx_start();
      chk("tx_retry", tx_idx_o, 32'h2);
      eng.tx_end();
      rd("abort_ack_sent", CMS_ADDR_ABORT_ACK, 32'h1);
      chk("tx_irq", tx_irq_o, 32'h1);
      apb(1'b1, CMS_ADDR_TX_SEL, 32'h2);
      rd("tx_stamp_hi", win(CMS_WIN_TX, CMS_TXW_STAMP_HI), tstamp[15:8]);
      apb(1'b1, win(CMS_WIN_TX, CMS_TXW_STAMP_LO), 32'h55);
      rd("tx_stamp_lo", win(CMS_WIN_TX, CMS_TXW_STAMP_LO), tstamp[7:0]);
      eng.rx_frame(1'b0, 1'b0, 8'hA0);
      rd("rx_reject", CMS_ADDR_RX_FLAG, 32'h0);
      eng.rx_frame(1'b1, 1'b1, 8'hA1);
      rd("rx_own", CMS_ADDR_RX_FLAG, 32'h0);
      for (int i = 1; i <= 6; i++)
         eng.rx_frame(1'b0, 1'b1, i[7:0]);
      rd("rx_overrun", CMS_ADDR_RX_FLAG, 32'h3);
      chk("rx_irq", rx_irq_o, 32'h1);
      chk("err_irq", err_irq_o, 32'h1);
      rd("rx_stamp", win(CMS_WIN_RX, CMS_RXW_STAMP_LO), tstamp[7:0]);
      rd("rx_first", win(CMS_WIN_RX, 4'h0), 32'h1);
      apb(1'b1, CMS_ADDR_RX_FLAG, 32'h1);
      apb(1'b1, CMS_ADDR_RX_FLAG, 32'h1);
      eng.rx_frame(1'b0, 1'b1, 8'h07);
      // oldest first: frames 3, 4, 5, then the one taken after stages freed
      for (int i = 0; i < 4; i++) begin
         rd("rx_order", win(CMS_WIN_RX, 4'h0), (i == 3) ? 32'h7 : 32'h3 + i);
         apb(1'b1, CMS_ADDR_RX_FLAG, 32'h1);
      end
      rd("rx_drained", CMS_ADDR_RX_FLAG, 32'h2);
      apb(1'b1, CMS_ADDR_CTRL, 32'h6);
      eng.rx_frame(1'b1, 1'b1, 8'h08);
      rd("loopback", win(CMS_WIN_RX, 4'h0), 32'h8);
      apb(1'b1, CMS_ADDR_CTRL, 32'h1);
      rd("timer_clear", CMS_ADDR_TIMER, 32'h0);
      print_verdict();
   end
endmodule // test_can_message_storage
